/* File: rtl/uart_flow_consts.svh */
// register offsets, field positions and timing counts of the flow control block
`ifndef UART_FLOW_CONSTS_SVH
`define UART_FLOW_CONSTS_SVH
// register byte offsets
`define OFF_EFR      8'h00
`define OFF_MCR      8'h04
`define OFF_IER      8'h08
`define OFF_LCR      8'h0C
`define OFF_FCR      8'h10
`define OFF_ISR      8'h14
`define OFF_RES1     8'h18
`define OFF_RES2     8'h1C
`define OFF_STOP1    8'h20
`define OFF_STOP2    8'h24
`define OFF_FLOWST   8'h28
// enhanced feature bits
`define EFR_SW_RX    0
`define EFR_DOUBLE   1
`define EFR_SW_TX    2
`define EFR_ENH      4
`define EFR_SPECIAL  5
`define EFR_ARTS     6
`define EFR_ACTS     7
// other field positions
`define MCR_RTS      1
`define MCR_IR       6
`define IER_RXTRIG   0
`define IER_STOP     5
`define IER_RTS      6
`define IER_CTS      7
`define ISR_STOP     4
`define ISR_HWFC     5
// reset value of all registers
`define REG_RST      8'h00
// 16x ticks
`define BIT_TICKS    4'hF
`define IR_PULSE     4'h3
`endif

/* File: rtl/uart_flow_pkg.sv */
// types shared by the flow control block
package uart_flow_pkg;
    // one received or sent character with its strobe
    typedef struct packed {
        logic       vld;
        logic [7:0] data;
    } char_s;
    // automatic stop/resume sender
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_WAIT  = 5'b00010,
        ST_STOP  = 5'b00100,
        ST_HELD  = 5'b01000,
        ST_RES   = 5'b10000
    } snd_e;
endpackage

/* File: rtl/uart_flow_ctl.sv */
// flow control, special character and infrared extensions of one serial channel
//
// Implementation choices: the address map and the APB slave port.
`include "uart_flow_consts.svh"
module uart_flow_ctl (
    // clock and reset
    input  logic                 pclk,
    input  logic                 presetn,
    // apb slave
    input  logic                 psel,
    input  logic                 penable,
    input  logic                 pwrite,
    input  logic [7:0]           paddr,
    input  logic [31:0]          pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    // timing and receive fifo fill
    input  logic                 tick16,
    input  logic [4:0]           rx_fill,
    // receive character path
    input  uart_flow_pkg::char_s rx_in,
    output uart_flow_pkg::char_s rx_out,
    // transmitter handshake
    output logic                 tx_go,
    output uart_flow_pkg::char_s ctl_char,
    input  logic                 ctl_take,
    input  logic                 tx_ser,
    input  logic                 tx_bit_start,
    // modem pins and serial pins
    output logic                 rts_n,
    input  logic                 cts_n,
    output logic                 tx_pin,
    input  logic                 rx_pin,
    output logic                 rx_ser,
    output logic                 irq
);
    logic [7:0]           enhanced_feature_reg_ff;
    logic [7:0]           modem_control_reg_ff;
    logic [7:0]           interrupt_enable_reg_ff;
    logic [7:0]           line_control_reg_ff;
    logic [1:0]           trig_sel_ff;
    logic [7:0]           res1_ff;
    logic [7:0]           res2_ff;
    logic [7:0]           stop1_ff;
    logic [7:0]           second_stop_character_ff;
    logic                 isr_stop_ff;
    logic                 isr_hwfc_ff;
    logic                 halt_ff;
    logic                 rts_hold_ff;
    logic                 rts_n_ff;
    logic                 cts_prev_ff;
    logic [31:0]          prdata_ff;
    uart_flow_pkg::char_s rx_out_ff;
    uart_flow_pkg::char_s pend_ff;
    uart_flow_pkg::char_s held_ff;
    logic                 held_stop_ff;
    uart_flow_pkg::snd_e  snd_ff;
    logic                 second_ff;
    logic [8:0]           wait_ff;
    logic [3:0]           irtx_ff;
    logic                 tx_pin_ff;
    logic [3:0]           irrx_ff;
    logic                 rx_prev_ff;
    logic                 rx_ser_ff;
    logic                 wr_acc;
    logic                 rd_isr;
    logic                 mapped;
    logic [7:0]           wmask;
    logic                 m_s1;
    logic                 m_s2;
    logic                 m_r1;
    logic                 m_r2;
    logic                 special;
    logic                 stop_hit;
    logic                 resume_hit;
    logic [4:0]           trig_lvl;
    logic [4:0]           low_lvl;
    logic [8:0]           two_chars;
    logic                 nxt_rts_n;
    logic                 ir_on;

    //----------------------------------------
    // register bus
    //----------------------------------------
    // zero wait access, read data latched in setup
    assign pready  = 1'b1;
    assign wr_acc  = psel & penable & pwrite;
    assign rd_isr  = psel & penable & ~pwrite & (paddr == `OFF_ISR);
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_ff;

    // address decode for the error response
    always_comb
    begin
        mapped = 1'b1;
        case (paddr)
            `OFF_EFR, `OFF_MCR, `OFF_IER, `OFF_LCR, `OFF_FCR, `OFF_ISR,
            `OFF_RES1, `OFF_RES2, `OFF_STOP1, `OFF_STOP2, `OFF_FLOWST: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // read data capture in setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h0000_0000;
        else if (psel & ~penable & ~pwrite)
        begin
            case (paddr)
                `OFF_EFR:    prdata_ff <= {24'h0, enhanced_feature_reg_ff};
                `OFF_MCR:    prdata_ff <= {24'h0, modem_control_reg_ff};
                `OFF_IER:    prdata_ff <= {24'h0, interrupt_enable_reg_ff};
                `OFF_LCR:    prdata_ff <= {24'h0, line_control_reg_ff};
                `OFF_FCR:    prdata_ff <= {30'h0, trig_sel_ff};
                `OFF_ISR:    prdata_ff <= {26'h0, isr_hwfc_ff, isr_stop_ff, 4'h0};
                `OFF_RES1:   prdata_ff <= {24'h0, res1_ff};
                `OFF_RES2:   prdata_ff <= {24'h0, res2_ff};
                `OFF_STOP1:  prdata_ff <= {24'h0, stop1_ff};
                `OFF_STOP2:  prdata_ff <= {24'h0, second_stop_character_ff};
                `OFF_FLOWST: prdata_ff <= {27'h0, snd_ff != uart_flow_pkg::ST_IDLE, held_ff.vld,
                                           rts_hold_ff, cts_n, halt_ff};
                default:     prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // control registers
    // characters reset zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enhanced_feature_reg_ff  <= `REG_RST;
            modem_control_reg_ff     <= `REG_RST;
            interrupt_enable_reg_ff  <= `REG_RST;
            line_control_reg_ff      <= `REG_RST;
            trig_sel_ff              <= 2'h0;
            res1_ff                  <= `REG_RST;
            res2_ff                  <= `REG_RST;
            stop1_ff                 <= `REG_RST;
            second_stop_character_ff <= `REG_RST;
        end
        else if (wr_acc)
        begin
            case (paddr)
                `OFF_EFR:   enhanced_feature_reg_ff  <= pwdata[7:0];
                `OFF_MCR:   modem_control_reg_ff     <= pwdata[7:0];
                `OFF_IER:   interrupt_enable_reg_ff  <= pwdata[7:0];
                `OFF_LCR:   line_control_reg_ff      <= pwdata[7:0];
                `OFF_FCR:   trig_sel_ff              <= pwdata[1:0];
                `OFF_RES1:  res1_ff                  <= pwdata[7:0];
                `OFF_RES2:  res2_ff                  <= pwdata[7:0];
                `OFF_STOP1: stop1_ff                 <= pwdata[7:0];
                `OFF_STOP2: second_stop_character_ff <= pwdata[7:0];
                default:    ;
            endcase
        end
    end

    //----------------------------------------
    // character matching
    //----------------------------------------
    // word length mask
    always_comb
    begin
        case (line_control_reg_ff[1:0])
            2'h0:    wmask = 8'h1F;
            2'h1:    wmask = 8'h3F;
            2'h2:    wmask = 8'h7F;
            default: wmask = 8'hFF;
        endcase
    end

    assign m_s1 = ((rx_in.data ^ stop1_ff) & wmask) == 8'h00;
    assign m_s2 = ((rx_in.data ^ second_stop_character_ff) & wmask) == 8'h00;
    assign m_r1 = ((rx_in.data ^ res1_ff) & wmask) == 8'h00;
    assign m_r2 = ((rx_in.data ^ res2_ff) & wmask) == 8'h00;
    assign special = enhanced_feature_reg_ff[`EFR_SPECIAL] & m_s2;

    assign stop_hit = rx_in.vld & enhanced_feature_reg_ff[`EFR_SW_RX] & ~special &
                      (enhanced_feature_reg_ff[`EFR_DOUBLE] ? (held_ff.vld & held_stop_ff & m_s2) : m_s1);
    assign resume_hit = rx_in.vld & enhanced_feature_reg_ff[`EFR_SW_RX] & ~special & ~stop_hit &
                        (enhanced_feature_reg_ff[`EFR_DOUBLE] ? (held_ff.vld & ~held_stop_ff & m_r2) : m_r1);

    // receive stream filter; a lone first character waits for the next one
    // flow characters dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_out_ff    <= '0;
            pend_ff      <= '0;
            held_ff      <= '0;
            held_stop_ff <= 1'b0;
        end
        else
        begin
            rx_out_ff.vld <= 1'b0;
            if (pend_ff.vld)
            begin
                rx_out_ff <= pend_ff;
                pend_ff   <= '0;
            end
            if (rx_in.vld)
            begin
                if (special | ~enhanced_feature_reg_ff[`EFR_SW_RX])
                    rx_out_ff <= rx_in;
                else if (~enhanced_feature_reg_ff[`EFR_DOUBLE])
                begin
                    if (~(m_s1 | m_r1))
                        rx_out_ff <= rx_in;
                end
                else if (held_ff.vld)
                begin
                    held_ff <= '0;
                    if (~(stop_hit | resume_hit))
                    begin
                        rx_out_ff <= held_ff;
                        if (m_s1 | m_r1)
                        begin
                            held_ff      <= rx_in;
                            held_stop_ff <= m_s1;
                        end
                        else
                            pend_ff <= rx_in;
                    end
                end
                else if (m_s1 | m_r1)
                begin
                    held_ff      <= rx_in;
                    held_stop_ff <= m_s1;
                end
                else
                    rx_out_ff <= rx_in;
            end
        end
    end
    assign rx_out = rx_out_ff;

    //----------------------------------------
    // transmit gating and status
    //----------------------------------------
    // software halt state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            halt_ff <= 1'b0;
        else if (stop_hit)
            halt_ff <= 1'b1;
        else if (resume_hit)
            halt_ff <= 1'b0;
    end

    assign tx_go = ~halt_ff & ~(enhanced_feature_reg_ff[`EFR_ACTS] & cts_n);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            isr_stop_ff <= 1'b0;
        else if (stop_hit | (rx_in.vld & special))
            isr_stop_ff <= 1'b1;
        else if (resume_hit | rd_isr)
            isr_stop_ff <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            isr_hwfc_ff <= 1'b0;
        else if (enhanced_feature_reg_ff[`EFR_ENH] &
                 ((interrupt_enable_reg_ff[`IER_RTS] & ~rts_n_ff & nxt_rts_n) |
                  (interrupt_enable_reg_ff[`IER_CTS] & ~cts_prev_ff & cts_n)))
            isr_hwfc_ff <= 1'b1;
        else if (rd_isr)
            isr_hwfc_ff <= 1'b0;
    end

    assign irq = (isr_stop_ff & interrupt_enable_reg_ff[`IER_STOP]) | isr_hwfc_ff |
                 (interrupt_enable_reg_ff[`IER_RXTRIG] & (rx_fill >= trig_lvl));

    //----------------------------------------
    // hardware request flow control
    //----------------------------------------
    // trigger level and paired low level
    always_comb
    begin
        case (trig_sel_ff)
            2'h0:    begin trig_lvl = 5'h01; low_lvl = 5'h00; end
            2'h1:    begin trig_lvl = 5'h04; low_lvl = 5'h01; end
            2'h2:    begin trig_lvl = 5'h08; low_lvl = 5'h04; end
            default: begin trig_lvl = 5'h0E; low_lvl = 5'h08; end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rts_hold_ff <= 1'b0;
        else if (rx_fill >= trig_lvl)
            rts_hold_ff <= 1'b1;
        else if (rx_fill <= low_lvl)
            rts_hold_ff <= 1'b0;
    end

    assign nxt_rts_n = ~(modem_control_reg_ff[`MCR_RTS] &
                         ~(enhanced_feature_reg_ff[`EFR_ARTS] & rts_hold_ff));

    // pin and edge history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rts_n_ff    <= 1'b1;
            cts_prev_ff <= 1'b1;
        end
        else
        begin
            rts_n_ff    <= nxt_rts_n;
            cts_prev_ff <= cts_n;
        end
    end
    assign rts_n = rts_n_ff;

    //----------------------------------------
    // automatic stop/resume sender
    //----------------------------------------
    // two characters of 16x ticks
    // start, five data and one stop bit is the shortest frame: seven bits
    assign two_chars = {(4'h7 + {2'h0, line_control_reg_ff[1:0]} + {3'h0, line_control_reg_ff[3]} +
                         {3'h0, line_control_reg_ff[2]}), 5'h00};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            snd_ff    <= uart_flow_pkg::ST_IDLE;
            second_ff <= 1'b0;
            wait_ff   <= 9'h000;
        end
        else
        begin
            case (snd_ff)
                uart_flow_pkg::ST_IDLE:
                    if (enhanced_feature_reg_ff[`EFR_SW_TX] & (rx_fill >= trig_lvl))
                    begin
                        snd_ff  <= uart_flow_pkg::ST_WAIT;
                        wait_ff <= two_chars;
                    end
                uart_flow_pkg::ST_WAIT:
                    if (wait_ff == 9'h000)
                        snd_ff <= uart_flow_pkg::ST_STOP;
                    else if (tick16)
                        wait_ff <= wait_ff - 9'h001;
                uart_flow_pkg::ST_STOP, uart_flow_pkg::ST_RES:
                    if (ctl_take)
                    begin
                        if (enhanced_feature_reg_ff[`EFR_DOUBLE] & ~second_ff)
                            second_ff <= 1'b1;
                        else
                        begin
                            second_ff <= 1'b0;
                            snd_ff    <= (snd_ff == uart_flow_pkg::ST_STOP) ?
                                         uart_flow_pkg::ST_HELD : uart_flow_pkg::ST_IDLE;
                        end
                    end
                uart_flow_pkg::ST_HELD:
                    if (rx_fill <= low_lvl)
                        snd_ff <= uart_flow_pkg::ST_RES;
                default:
                    snd_ff <= uart_flow_pkg::ST_IDLE;
            endcase
        end
    end

    // character offered to the transmitter
    always_comb
    begin
        ctl_char.vld  = (snd_ff == uart_flow_pkg::ST_STOP) | (snd_ff == uart_flow_pkg::ST_RES);
        ctl_char.data = (snd_ff == uart_flow_pkg::ST_STOP) ? (second_ff ? second_stop_character_ff : stop1_ff)
                                                           : (second_ff ? res2_ff : res1_ff);
    end

    //----------------------------------------
    // infrared encoder and decoder
    //----------------------------------------
    assign ir_on = modem_control_reg_ff[`MCR_IR];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irtx_ff   <= 4'h0;
            tx_pin_ff <= 1'b1;
        end
        else
        begin
            if (tx_bit_start & ~tx_ser)
                irtx_ff <= `IR_PULSE;
            else if (tick16 & (irtx_ff != 4'h0))
                irtx_ff <= irtx_ff - 4'h1;
            tx_pin_ff <= ir_on ? (irtx_ff != 4'h0) : tx_ser;
        end
    end
    assign tx_pin = tx_pin_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irrx_ff    <= 4'h0;
            rx_prev_ff <= 1'b0;
            rx_ser_ff  <= 1'b1;
        end
        else
        begin
            rx_prev_ff <= rx_pin;
            if (rx_pin & ~rx_prev_ff)
                irrx_ff <= `BIT_TICKS;
            else if (tick16 & (irrx_ff != 4'h0))
                irrx_ff <= irrx_ff - 4'h1;
            rx_ser_ff <= ir_on ? ((irrx_ff != 4'h0) | (rx_pin & ~rx_prev_ff)) : rx_pin;
        end
    end
    assign rx_ser = rx_ser_ff;

    //----------------------------------------
    // assertions
    //----------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cts_gate_tx: assert property (enhanced_feature_reg_ff[`EFR_ACTS] && cts_n |-> !tx_go)
        else $error("transmit allowed while clear input high");
    a_halt_on_stop: assert property (stop_hit |=> halt_ff && !tx_go)
        else $error("stop match did not halt transmit");
    a_resume_clear: assert property (resume_hit |=> !halt_ff && !isr_stop_ff)
        else $error("resume match did not release");
    a_flow_dropped: assert property (rx_in.vld && !special && enhanced_feature_reg_ff[`EFR_SW_RX] &&
        !enhanced_feature_reg_ff[`EFR_DOUBLE] && (m_s1 || m_r1) && !pend_ff.vld |=> !rx_out.vld)
        else $error("flow character reached fifo");
    a_special_kept: assert property (rx_in.vld && special |=> rx_out.vld && isr_stop_ff)
        else $error("special character lost or flag missing");
    a_rts_hold: assert property (enhanced_feature_reg_ff[`EFR_ARTS] && rx_fill >= trig_lvl ##1
        enhanced_feature_reg_ff[`EFR_ARTS] |=> rts_n)
        else $error("request not dropped at threshold");
    a_rts_event: assert property (enhanced_feature_reg_ff[`EFR_ENH] && interrupt_enable_reg_ff[`IER_RTS] &&
        $rose(rts_n) |-> isr_hwfc_ff)
        else $error("request rise not flagged");
    a_cts_event: assert property (enhanced_feature_reg_ff[`EFR_ENH] && interrupt_enable_reg_ff[`IER_CTS] &&
        $rose(cts_n) |=> isr_hwfc_ff)
        else $error("clear rise not flagged");
    a_stop_irq: assert property (stop_hit && interrupt_enable_reg_ff[`IER_STOP] |=> irq)
        else $error("stop match without interrupt");
    a_ir_idle: assert property (ir_on && irtx_ff == 4'h0 |=> !tx_pin)
        else $error("infrared output not idle low");
    a_ir_pulse: assert property (ir_on && tx_bit_start && !tx_ser |=> irtx_ff == 4'h3)
        else $error("infrared pulse width wrong");
    a_stop_delay: assert property (snd_ff == uart_flow_pkg::ST_IDLE ##1 snd_ff == uart_flow_pkg::ST_WAIT
        |-> wait_ff == $past(two_chars))
        else $error("stop send delay not two characters");
endmodule

/* File: test/uart_flow_partner.sv */
// far-side model: 16x tick source and a slow transmitter taking flow characters
module uart_flow_partner (
    // clock and reset
    input  logic                 pclk,
    input  logic                 presetn,
    // transmitter side
    input  uart_flow_pkg::char_s ctl_char,
    output logic                 ctl_take,
    output logic                 tick16
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] age_ff;
    // tick every other clock, accept an offered character four cycles late
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick16   <= 1'b0;
            ctl_take <= 1'b0;
            age_ff   <= 2'h0;
        end
        else
        begin
            tick16   <= ~tick16;
            ctl_take <= ctl_char.vld && !ctl_take && age_ff == 2'h3;
            age_ff   <= (ctl_char.vld && !ctl_take) ? age_ff + 2'h1 : 2'h0;
        end
    end
endmodule

/* File: test/uart_flow_control_irda_bench.sv */
// self-checking bench of the flow control block
`include "uart_flow_consts.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module uart_flow_control_irda_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv_err;
    logic [7:0]           paddr = 8'h00;
    logic [31:0]          pwdata = 32'h0, prdata, rd, v;
    logic                 pready, pslverr, tick16, ctl_take, tx_go, rts_n, tx_pin, rx_ser, irq;
    logic [4:0]           rx_fill = 5'h00;
    logic                 cts_n = 0, tx_ser = 1, tx_bit_start = 0, rx_pin = 0;
    uart_flow_pkg::char_s rx_in = '0, rx_out, ctl_char;
    int                   error_cnt = 0, n_compared = 0;
    uart_flow_ctl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tick16(tick16),
        .rx_fill(rx_fill), .rx_in(rx_in), .rx_out(rx_out), .tx_go(tx_go), .ctl_char(ctl_char),
        .ctl_take(ctl_take), .tx_ser(tx_ser), .tx_bit_start(tx_bit_start), .rts_n(rts_n), .cts_n(cts_n),
        .tx_pin(tx_pin), .rx_pin(rx_pin), .rx_ser(rx_ser), .irq(irq));
    uart_flow_partner u_far (.pclk(pclk), .presetn(presetn), .ctl_char(ctl_char), .ctl_take(ctl_take),
        .tick16(tick16));
    // clock
    always #2 pclk = ~pclk;
    // expected register readback and paired low fill
    function automatic logic [31:0] reg_exp(input logic [7:0] d);
        return {24'h000000, d};
    endfunction
    function automatic logic [4:0] low_lvl(input int idx);
        return (idx == 3) ? 5'h08 : (idx == 2) ? 5'h04 : (idx == 1) ? 5'h01 : 5'h00;
    endfunction
    // apb transfer, read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv_err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // one received character, checked one cycle later
    task automatic send(input logic [7:0] d, input logic pass);
        @(posedge pclk) rx_in <= {1'b1, d};
        @(posedge pclk) rx_in <= '0;
        #1 `CHK(rx_out.vld, pass)
        if (pass) `CHK(rx_out.data, d)
        repeat (3) @(posedge pclk);
    endtask
    // bounded wait for an offered flow character
    task automatic wait_ctl(input logic [7:0] d);
        int n;
        n = 0;
        while (ctl_char.vld !== 1'b1 && n < 3000)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK(ctl_char.data, d)
        repeat (12) @(posedge pclk);
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // main sequence
    initial
    begin
        void'($urandom(32'h7B0D));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = `OFF_RES1; a <= `OFF_STOP2; a += 4)
        begin
            apb(1'b0, 8'(a), 32'h0);
            `CHK(rd, 32'h0)
        end
        for (int i = 0; i < 4; i++)
        begin
            v = $urandom;
            apb(1'b1, `OFF_STOP2, v);
            apb(1'b0, `OFF_STOP2, 32'h0);
            `CHK(rd, reg_exp(v[7:0]))
        end
        apb(1'b0, 8'hFC, 32'h0);
        `CHK(slv_err, 1'b1)
        $display("register test done");
        apb(1'b1, `OFF_STOP1, 32'h13);
        apb(1'b1, `OFF_RES1, 32'h11);
        apb(1'b1, `OFF_IER, 32'h20);
        apb(1'b1, `OFF_EFR, 32'h01);
        v = $urandom;
        send({v[2:0], 5'h0A}, 1'b1);
        send(8'hF3, 1'b0);
        `CHK(tx_go, 1'b0)
        `CHK(irq, 1'b1)
        send(8'h31, 1'b0);
        `CHK(tx_go, 1'b1)
        `CHK(irq, 1'b0)
        apb(1'b1, `OFF_STOP2, 32'h05);
        apb(1'b1, `OFF_RES2, 32'h06);
        apb(1'b1, `OFF_EFR, 32'h03);
        send(8'h13, 1'b0);
        send(8'h05, 1'b0);
        `CHK(tx_go, 1'b0)
        send(8'h11, 1'b0);
        send(8'h06, 1'b0);
        `CHK(tx_go, 1'b1)
        apb(1'b1, `OFF_EFR, 32'h21);
        send(8'h05, 1'b1);
        `CHK(irq, 1'b1)
        $display("stop resume test done");
        apb(1'b1, `OFF_EFR, 32'h50);
        apb(1'b1, `OFF_IER, 32'h40);
        apb(1'b1, `OFF_FCR, 32'h2);
        apb(1'b1, `OFF_MCR, 32'h2);
        rx_fill <= 5'h07;
        repeat (3) @(posedge pclk);
        `CHK(rts_n, 1'b0)
        for (int f = 8; f >= 4; f--)
        begin
            rx_fill <= 5'(f);
            repeat (3) @(posedge pclk);
            `CHK(rts_n, f > low_lvl(2))
            if (f == 8) `CHK(irq, 1'b1)
        end
        $display("request test done");
        apb(1'b1, `OFF_IER, 32'h80);
        apb(1'b1, `OFF_EFR, 32'h90);
        apb(1'b0, `OFF_ISR, 32'h0);
        `CHK(rd[5], 1'b1)
        @(posedge pclk) cts_n <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK(tx_go, 1'b0)
        `CHK(irq, 1'b1)
        @(posedge pclk) cts_n <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK(tx_go, 1'b1)
        $display("clear input test done");
        rx_fill <= 5'h00;
        apb(1'b1, `OFF_EFR, 32'h04);
        apb(1'b1, `OFF_FCR, 32'h0);
        rx_fill <= 5'h01;
        repeat (100) @(posedge pclk);
        `CHK(ctl_char.vld, 1'b0)
        wait_ctl(8'h13);
        rx_fill <= low_lvl(0);
        wait_ctl(8'h11);
        apb(1'b1, `OFF_MCR, 32'h40);
        repeat (3) @(posedge pclk);
        `CHK(tx_pin, 1'b0)
        `CHK(rx_ser, 1'b0)
        @(posedge pclk) {tx_bit_start, tx_ser} <= 2'b10;
        @(posedge pclk) tx_bit_start <= 1'b0;
        @(posedge pclk);
        #1 `CHK(tx_pin, 1'b1)
        repeat (10) @(posedge pclk);
        `CHK(tx_pin, 1'b0)
        tx_ser <= 1'b1;
        @(posedge pclk) rx_pin <= 1'b1;
        @(posedge pclk) rx_pin <= 1'b0;
        #1 `CHK(rx_ser, 1'b1)
        $display("send and infrared test done");
        summarize();
    end
    // watchdog
    initial
    begin
        #200000;
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        summarize();
    end
endmodule
